// ---- rtl/adc_trigger_defines.vh ----
// constants for the converter trigger and register block
// Functional notes
// - compare mode 1011 plus converter on: trigger sets go/done, starts conversion
// - every trigger clears the selected timer counter to zero
// - converter off: trigger ignored by converter, timer still cleared
// - control one: clock sel 7:6, channel 5:3, go 2, bit1 zero, on 0
// - control two: justify 7, clock sel hi 6, 5:4 zero, port config 3:0
// - done flag, enable, priority at bit 6 of flag/enable/priority registers
// - unimplemented control bits read zero; interrupt registers keep all eight written bits
// - justify set right-justifies result; clear left-justifies, zero padding
// - three clock-select bits choose divide 2,8,32,4,16,64 or rc clock
`ifndef ADC_TRIGGER_DEFINES_VH
`define ADC_TRIGGER_DEFINES_VH
`define ADR_FLAGS_ONE      3'h0
`define ADR_ENABLES_ONE    3'h1
`define ADR_PRIORITY_ONE   3'h2
`define ADR_RESULT_HIGH    3'h3
`define ADR_RESULT_LOW     3'h4
`define ADR_CONTROL_FIRST  3'h5
`define ADR_CONTROL_SECOND 3'h6
`define ADR_GLOBAL_INT     3'h7
`define BIT_CONV_DONE      6
`define BIT_GO             2
`define BIT_ON             0
`define BIT_JUSTIFY        7
`define CTRL_FIRST_MASK    8'hfd
`define CTRL_SECOND_MASK   8'hcf
`define RESET_BYTE         8'h00
`define SPECIAL_EVENT_MODE 4'hb
`define CONV_BIT_CLOCKS    12
`define RC_DIVIDE          8'h04
`endif

// ---- rtl/adc_event_trigger_ctrl.v ----
// converter control with special-event trigger, register file and conversion sequencer
`timescale 1ns/1ns
`include "adc_trigger_defines.vh"
module adc_event_trigger_ctrl #(
    parameter RESULT_WIDTH = 10
) (
    input  wire        MCLK,
    input  wire        RESET_N,
    input  wire [2:0]  ADDR,
    input  wire [7:0]  WDATA,
    input  wire        WR,
    input  wire        RD,
    output reg  [7:0]  RDATA,
    input  wire [3:0]  COMPARE_TWO_MODE,
    input  wire        SPECIAL_EVENT,
    input  wire        TIMER_THREE_SELECT,
    input  wire [9:0]  SAMPLE_VALUE,
    output reg         TIMER_ONE_CLEAR,
    output reg         TIMER_THREE_CLEAR,
    output reg  [2:0]  CHANNEL,
    output reg  [3:0]  PORT_CONFIG,
    output reg         CONV_DONE_IRQ,
    output reg         CONV_DONE_HIGH_PRIO
);
    localparam ST_IDLE = 2'd0;
    localparam ST_CONV = 2'd1;
    localparam ST_DONE = 2'd2;

    reg [7:0]  flags_one;
    reg [7:0]  enables_one;
    reg [7:0]  priority_one;
    reg [7:0]  global_int;
    reg [7:0]  control_first;
    reg [7:0]  control_second;
    reg [7:0]  result_high;
    reg [7:0]  result_low;
    reg [1:0]  state;
    reg [7:0]  clk_div;
    reg [3:0]  bit_count;
    reg [7:0]  tick_limit;
    reg [9:0]  held_sample;
    reg [9:0]  sample_meta;
    reg [9:0]  sample_sync;
    reg        evt_meta;
    reg        evt_sync;
    reg        evt_prev;
    reg [7:0]  read_value;
    wire       trigger;
    wire       conv_tick;
    wire       finish;
    wire [2:0] clock_code;

    // trigger is an edge of the synchronised special-event level
    assign trigger    = evt_sync & ~evt_prev;
    assign clock_code = {control_second[6], control_first[7:6]};
    assign conv_tick  = (clk_div == tick_limit);
    assign finish     = (state == ST_CONV) && conv_tick && (bit_count == `CONV_BIT_CLOCKS - 1);

    always @* begin
        case (clock_code)
            3'b000: tick_limit = 8'h01;
            3'b001: tick_limit = 8'h07;
            3'b010: tick_limit = 8'h1f;
            3'b100: tick_limit = 8'h03;
            3'b101: tick_limit = 8'h0f;
            3'b110: tick_limit = 8'h3f;
            default: tick_limit = `RC_DIVIDE - 8'h01;
        endcase
    end

    always @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            evt_meta    <= 1'b0;
            evt_sync    <= 1'b0;
            evt_prev    <= 1'b0;
            sample_meta <= 10'h000;
            sample_sync <= 10'h000;
        end else begin
            evt_meta    <= SPECIAL_EVENT;
            evt_sync    <= evt_meta;
            evt_prev    <= evt_sync;
            sample_meta <= SAMPLE_VALUE;
            sample_sync <= sample_meta;
        end
    end

    // timer clear pulses follow every trigger, converter on or off
    always @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            TIMER_ONE_CLEAR   <= 1'b0;
            TIMER_THREE_CLEAR <= 1'b0;
        end else begin
            TIMER_ONE_CLEAR   <= trigger & ~TIMER_THREE_SELECT;
            TIMER_THREE_CLEAR <= trigger & TIMER_THREE_SELECT;
        end
    end

    // results kept out of the reset so they survive non-power resets
    always @(posedge MCLK) begin
        if (finish) begin
            if (control_second[`BIT_JUSTIFY]) begin
                result_high <= {6'h00, held_sample[9:8]};
                result_low  <= held_sample[7:0];
            end else begin
                result_high <= held_sample[9:2];
                result_low  <= {held_sample[1:0], 6'h00};
            end
        end
    end

    always @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state       <= ST_IDLE;
            clk_div     <= 8'h00;
            bit_count   <= 4'h0;
            held_sample <= 10'h000;
        end else begin
            case (state)
                ST_IDLE: begin
                    clk_div   <= 8'h00;
                    bit_count <= 4'h0;
                    if (control_first[`BIT_GO] && control_first[`BIT_ON]) begin
                        state       <= ST_CONV;
                        held_sample <= sample_sync;
                    end
                end
                ST_CONV: begin
                    if (!control_first[`BIT_ON] || !control_first[`BIT_GO]) begin
                        state <= ST_IDLE;
                    end else if (conv_tick) begin
                        clk_div   <= 8'h00;
                        bit_count <= bit_count + 4'h1;
                        if (finish) begin
                            state <= ST_DONE;
                        end
                    end else begin
                        clk_div <= clk_div + 8'h01;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    always @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            flags_one      <= `RESET_BYTE;
            enables_one    <= `RESET_BYTE;
            priority_one   <= `RESET_BYTE;
            global_int     <= `RESET_BYTE;
            control_first  <= `RESET_BYTE;
            control_second <= `RESET_BYTE;
        end else begin
            if (WR) begin
                if (ADDR == `ADR_FLAGS_ONE) begin
                    flags_one <= WDATA;
                end else if (ADDR == `ADR_ENABLES_ONE) begin
                    enables_one <= WDATA;
                end else if (ADDR == `ADR_PRIORITY_ONE) begin
                    priority_one <= WDATA;
                end else if (ADDR == `ADR_GLOBAL_INT) begin
                    global_int <= WDATA;
                end else if (ADDR == `ADR_CONTROL_FIRST) begin
                    control_first <= WDATA & `CTRL_FIRST_MASK;
                end else if (ADDR == `ADR_CONTROL_SECOND) begin
                    control_second <= WDATA & `CTRL_SECOND_MASK;
                end
            end
            // hardware events placed after the write so they override it; finish clearing go wins over a trigger set
            if (trigger && COMPARE_TWO_MODE == `SPECIAL_EVENT_MODE
                    && control_first[`BIT_ON]) begin
                control_first[`BIT_GO] <= 1'b1;
            end
            if (finish) begin
                control_first[`BIT_GO]     <= 1'b0;
                flags_one[`BIT_CONV_DONE]  <= 1'b1;
            end
        end
    end

    always @* begin
        read_value = 8'h00;
        if (ADDR == `ADR_FLAGS_ONE) begin
            read_value = flags_one;
        end else if (ADDR == `ADR_ENABLES_ONE) begin
            read_value = enables_one;
        end else if (ADDR == `ADR_PRIORITY_ONE) begin
            read_value = priority_one;
        end else if (ADDR == `ADR_GLOBAL_INT) begin
            read_value = global_int;
        end else if (ADDR == `ADR_RESULT_HIGH) begin
            read_value = result_high;
        end else if (ADDR == `ADR_RESULT_LOW) begin
            read_value = result_low;
        end else if (ADDR == `ADR_CONTROL_FIRST) begin
            read_value = control_first;
        end else if (ADDR == `ADR_CONTROL_SECOND) begin
            read_value = control_second;
        end
    end

    always @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            RDATA               <= 8'h00;
            CHANNEL             <= 3'h0;
            PORT_CONFIG         <= 4'h0;
            CONV_DONE_IRQ       <= 1'b0;
            CONV_DONE_HIGH_PRIO <= 1'b0;
        end else begin
            RDATA               <= RD ? read_value : 8'h00;
            CHANNEL             <= control_first[5:3];
            PORT_CONFIG         <= control_second[3:0];
            CONV_DONE_IRQ       <= flags_one[`BIT_CONV_DONE] & enables_one[`BIT_CONV_DONE];
            CONV_DONE_HIGH_PRIO <= priority_one[`BIT_CONV_DONE];
        end
    end
endmodule

// ---- sim/trigger_source_model.sv ----
// far side: compare event line and the two timer counters it clears
`timescale 1ns/1ns
module trigger_source_model (
    input  wire        clk,
    input  wire        fire,
    input  wire        t1_clr,
    input  wire        t3_clr,
    output reg         event_line = 1'b0,
    output reg  [15:0] timer_one = 16'h0000,
    output reg  [15:0] timer_three = 16'h0000
);
    // timers free-run, so a missed clear shows up as a large count
    always @(posedge clk) begin
        event_line <= fire;
        timer_one <= t1_clr ? 16'h0000 : timer_one + 16'h0001;
        timer_three <= t3_clr ? 16'h0000 : timer_three + 16'h0001;
    end
endmodule

// ---- sim/adc_event_trigger_ctrl_properties.sv ----
// port assertions for the converter trigger block
`timescale 1ns/1ns
module trig_props (
    input wire       MCLK,
    input wire       RESET_N,
    input wire [2:0] ADDR,
    input wire [7:0] WDATA,
    input wire       WR,
    input wire       RD,
    input wire [7:0] RDATA,
    input wire       SPECIAL_EVENT,
    input wire       TIMER_THREE_SELECT,
    input wire       TIMER_ONE_CLEAR,
    input wire       TIMER_THREE_CLEAR,
    input wire [2:0] CHANNEL,
    input wire       CONV_DONE_IRQ,
    input wire       CONV_DONE_HIGH_PRIO
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RESET_N);
    property p_clr; $rose(SPECIAL_EVENT) |-> ##[2:6] TIMER_ONE_CLEAR || TIMER_THREE_CLEAR; endproperty
    a_clr: assert property (p_clr) else $error("no timer clear");
    property p_pulse; TIMER_ONE_CLEAR || TIMER_THREE_CLEAR |=> !TIMER_ONE_CLEAR && !TIMER_THREE_CLEAR; endproperty
    a_pulse: assert property (p_pulse) else $error("clear too long");
    property p_sel; TIMER_ONE_CLEAR || TIMER_THREE_CLEAR |-> TIMER_THREE_CLEAR == TIMER_THREE_SELECT; endproperty
    a_sel: assert property (p_sel) else $error("wrong timer cleared");
    property p_bit1; RD && ADDR == 3'h5 |=> RDATA[1] == 1'b0; endproperty
    a_bit1: assert property (p_bit1) else $error("control one bit1 set");
    property p_gap; RD && ADDR == 3'h6 |=> RDATA[5:4] == 2'b00; endproperty
    a_gap: assert property (p_gap) else $error("control two gap set");
    property p_prio; WR && ADDR == 3'h2 |-> ##2 CONV_DONE_HIGH_PRIO == $past(WDATA[6], 2); endproperty
    a_prio: assert property (p_prio) else $error("priority not followed");
    property p_chan; $changed(CHANNEL) |-> $past(WR) && $past(ADDR) == 3'h5
        || $past(WR, 2) && $past(ADDR, 2) == 3'h5; endproperty
    a_chan: assert property (p_chan) else $error("channel moved alone");
    property p_rst; disable iff (1'b0) !RESET_N |-> !TIMER_ONE_CLEAR && !CONV_DONE_IRQ; endproperty
    a_rst: assert property (p_rst) else $error("output set in reset");
endmodule
bind adc_event_trigger_ctrl trig_props trig_props_inst (.MCLK(MCLK), .RESET_N(RESET_N),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .CHANNEL(CHANNEL),
    .SPECIAL_EVENT(SPECIAL_EVENT), .TIMER_THREE_SELECT(TIMER_THREE_SELECT),
    .TIMER_ONE_CLEAR(TIMER_ONE_CLEAR), .TIMER_THREE_CLEAR(TIMER_THREE_CLEAR),
    .CONV_DONE_IRQ(CONV_DONE_IRQ), .CONV_DONE_HIGH_PRIO(CONV_DONE_HIGH_PRIO));

// ---- sim/tb_adc_event_trigger_ctrl.sv ----
// self-checking bench for the converter trigger block
`timescale 1ns/1ns
`include "adc_trigger_defines.vh"
module tb_adc_event_trigger_ctrl;
    reg         mclk = 0, reset_n = 1, wr = 0, rd = 0, sel3 = 0, fire = 0;
    reg  [2:0]  addr = 0;
    reg  [7:0]  wdata = 0;
    reg  [3:0]  mode = 0;
    reg  [9:0]  sample = 0;
    wire [7:0]  rdata;
    wire        t1, t3, irq, prio, ev;
    wire [2:0]  chan;
    wire [3:0]  pcfg;
    wire [15:0] tm1, tm3;
    logic [7:0] ex [0:7];
    logic [7:0] got;
    integer     error_cnt = 0, num_checks = 0, cycles = 0, i, j, n;
    always #50 mclk = ~mclk;
    adc_event_trigger_ctrl adc_event_trigger_ctrl_inst (.MCLK(mclk), .RESET_N(reset_n),
        .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .COMPARE_TWO_MODE(mode),
        .SPECIAL_EVENT(ev), .TIMER_THREE_SELECT(sel3), .SAMPLE_VALUE(sample),
        .TIMER_ONE_CLEAR(t1), .TIMER_THREE_CLEAR(t3), .CHANNEL(chan), .PORT_CONFIG(pcfg),
        .CONV_DONE_IRQ(irq), .CONV_DONE_HIGH_PRIO(prio));
    trigger_source_model trigger_source_model_inst (.clk(mclk), .fire(fire), .t1_clr(t1),
        .t3_clr(t3), .event_line(ev), .timer_one(tm1), .timer_three(tm3));
    task stop_test;
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            error_cnt = error_cnt + 1;
            stop_test;
        end
    end
    task chk(input logic [7:0] g, input logic [7:0] e);
        num_checks = num_checks + 1;
        if (g !== e) begin
            error_cnt = error_cnt + 1;
            $display("MISMATCH %0t got %h exp %h", $time, g, e);
        end
    endtask
    task wreg(input [2:0] a, input [7:0] d);
        @(posedge mclk) begin addr <= a; wdata <= d; wr <= 1'b1; end
        @(posedge mclk) wr <= 1'b0;
        ex[a] = d & (a == 5 ? `CTRL_FIRST_MASK : a == 6 ? `CTRL_SECOND_MASK : 8'hff);
    endtask
    task rreg(input [2:0] a);
        @(posedge mclk) begin addr <= a; rd <= 1'b1; end
        @(posedge mclk) rd <= 1'b0;
        #1 got = rdata;
    endtask
    task creg(input [2:0] a);
        rreg(a);
        chk(got, ex[a]);
    endtask
    task conv(input [3:0] m);
        @(posedge mclk) begin mode <= m; sel3 <= n[20]; sample <= n[29:20]; fire <= 1'b1; end
        repeat (5) @(posedge mclk);
        fire <= 1'b0;
        repeat (3) @(posedge mclk);
        chk({6'h0, (sel3 ? tm3 : tm1) < 8, (sel3 ? tm1 : tm3) > 8}, 8'h03);
        ex[5][2] = ex[5][0] && m == `SPECIAL_EVENT_MODE;
        creg(3'h5);
        if (ex[5][2]) begin
            got = 8'h00;
            for (j = 0; j < 1000 && got[6] !== 1'b1; j++) rreg(3'h0);
            ex[0][6] = 1'b1;
            ex[5][2] = 1'b0;
            ex[3] = ex[6][7] ? {6'h00, sample[9:8]} : sample[9:2];
            ex[4] = ex[6][7] ? sample[7:0] : {sample[1:0], 6'h00};
            for (j = 0; j < 6; j++) creg(j[2:0]);
            chk({7'h0, irq}, 8'h01);
            wreg(3'h0, 8'h00);
        end
    endtask
    initial begin
        // reset falls before the first edge so no output is sampled unknown
        #10 reset_n = 1'b0;
        n = $urandom(32'h1225702e);
        for (i = 0; i < 8; i++) ex[i] = 8'h00;
        repeat (8) @(posedge mclk);
        reset_n <= 1'b1;
        for (i = 0; i < 7; i++) if (i != 3 && i != 4) creg(i[2:0]);
        for (i = 0; i < 15; i++) begin
            j = (i % 5 == 4) ? 5 : (i % 5 == 3) ? 7 : (i % 5 == 2) ? 6 : i % 5 + 1;
            n = $urandom;
            wreg(j[2:0], j == 5 ? n[7:0] & 8'hfb : j < 3 ? n[7:0] & 8'h7f : n[7:0]);
            creg(j[2:0]);
            chk({prio, chan, pcfg}, {ex[2][6], ex[5][5:3], ex[6][3:0]});
        end
        wreg(3'h1, 8'h40);
        for (i = 0; i < 6; i++) begin
            n = $urandom;
            wreg(3'h6, n[7:0]);
            wreg(3'h5, {n[15:11], 2'b00, i != 1});
            conv(i == 2 ? n[19:16] & 4'h7 : `SPECIAL_EVENT_MODE);
        end
        @(posedge mclk) reset_n <= 1'b0;
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        for (i = 0; i < 7; i++) begin
            if (i != 3 && i != 4) ex[i] = 8'h00;
            creg(i[2:0]);
        end
        stop_test;
    end
endmodule
